// ### rtl/io_pin_function_mux.sv
// Purpose: Per-pin function multiplexer between peripherals and pads.
// Assumes: One clock; selector writes come from a system control port.
// Notes:   Function 1 is the routing matrix path on every pin.
`timescale 1ns/1ps
module io_pin_function_mux #(
  parameter int PINS = io_mux_pkg::PIN_COUNT
) (
  input  wire logic            clk,
  input  wire logic            rst,
  // Selector write port
  input  wire logic            selWrite,
  input  wire logic [4:0]      selPin,
  input  wire logic [1:0]      selData,
  output logic [2*PINS-1:0]    selState,
  // Pads
  input  wire logic [PINS-1:0] padIn,
  output logic [PINS-1:0]      padOut,
  output logic [PINS-1:0]      padOe,
  // Routing matrix side
  input  wire logic [PINS-1:0] matrixOut,
  input  wire logic [PINS-1:0] matrixOe,
  output logic [PINS-1:0]      matrixIn,
  // Test port
  output logic                 test_mode_select_in,
  output logic                 test_serial_in,
  output logic                 test_clock_in,
  input  wire logic            test_serial_out,
  input  wire logic            testOutOe,
  // Serial port 0
  input  wire logic            serial0_transmit,
  output logic                 serial0_receive,
  // Flash port: out and oe come from controller, in back to it
  input  wire logic [5:0]      flashOut,
  input  wire logic [5:0]      flashOe,
  output logic [5:0]           flashIn,
  // Fast port lines: dout, din, hold, wp, clock
  input  wire logic [4:0]      fastOut,
  input  wire logic [4:0]      fastOe,
  output logic [4:0]           fastIn,
  input  wire logic [5:0]      fast_port_chip_selects,
  input  wire logic [5:0]      fastCsOe,
  output logic                 fastCs0In,
  // Card port: cmd, clk, data 0..3
  input  wire logic [5:0]      sdioOut,
  input  wire logic [5:0]      sdioOe,
  output logic [5:0]           sdioIn
);

  // -------------------------------------------------------------
  // Per-pin function wiring tables
  // -------------------------------------------------------------
  logic [2:0] fnOut [PINS];
  logic [2:0] fnOe  [PINS];
  logic [2:0] fnIn  [PINS];

  // Flash order: cs, dout, wp, hold, clock, din
  localparam int FLASH_PIN [6] = '{io_mux_pkg::PIN_FLASH_CS, io_mux_pkg::PIN_FLASH_DOUT,
                                   io_mux_pkg::PIN_FLASH_WP, io_mux_pkg::PIN_FLASH_HOLD,
                                   io_mux_pkg::PIN_FLASH_CLK, io_mux_pkg::PIN_FLASH_DIN};

  function automatic io_mux_pkg::dir_type_t type0(input int p);
    if (p >= io_mux_pkg::PIN_TEST_MODE && p <= io_mux_pkg::PIN_TEST_CLOCK) begin
      return io_mux_pkg::TYPE_IN_HIGH;
    end
    if (p == io_mux_pkg::PIN_TEST_OUT || p == io_mux_pkg::PIN_FLASH_CS ||
        p == io_mux_pkg::PIN_FLASH_CLK) begin
      return io_mux_pkg::TYPE_OUT_TRI;
    end
    if (p == io_mux_pkg::PIN_SERIAL_TX) begin
      return io_mux_pkg::TYPE_OUT;
    end
    if (p == io_mux_pkg::PIN_SERIAL_RX || p == io_mux_pkg::PIN_SDIO_CLK) begin
      return io_mux_pkg::TYPE_IN_HIGH;
    end
    if (p == io_mux_pkg::PIN_FLASH_DOUT || p == io_mux_pkg::PIN_FLASH_WP ||
        p == io_mux_pkg::PIN_FLASH_HOLD || p == io_mux_pkg::PIN_FLASH_DIN ||
        p == io_mux_pkg::PIN_SDIO_CMD || (p >= io_mux_pkg::PIN_SDIO_DATA0 && p <= 23)) begin
      return io_mux_pkg::TYPE_IN_HIGH_OT;
    end
    return io_mux_pkg::TYPE_IN_OUT;
  endfunction

  function automatic io_mux_pkg::dir_type_t type2(input int p);
    if (p == io_mux_pkg::PIN_FAST_DATA_OUT ||
        (p >= io_mux_pkg::PIN_TEST_MODE && p <= io_mux_pkg::PIN_TEST_OUT) ||
        p == io_mux_pkg::PIN_CS_FIRST) begin
      return io_mux_pkg::TYPE_IN_HIGH_OT;
    end
    if (p > io_mux_pkg::PIN_CS_FIRST &&
        p < io_mux_pkg::PIN_CS_FIRST + io_mux_pkg::FAST_CS_COUNT) begin
      return io_mux_pkg::TYPE_OUT_TRI;
    end
    return io_mux_pkg::TYPE_NONE;
  endfunction

  // Function 0 and 2 sources per pin; default is the matrix-only pin
  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      fnOut[p] = {1'b0, matrixOut[p], 1'b0};
      fnOe[p]  = {1'b0, matrixOe[p], 1'b0};
    end
    fnOut[io_mux_pkg::PIN_TEST_OUT][0] = test_serial_out;
    fnOe[io_mux_pkg::PIN_TEST_OUT][0]  = testOutOe;
    fnOut[io_mux_pkg::PIN_SERIAL_TX][0] = serial0_transmit;
    fnOe[io_mux_pkg::PIN_SERIAL_TX][0]  = 1'b1;
    for (int k = 0; k < 6; k++) begin
      fnOut[FLASH_PIN[k]][0] = flashOut[k];
      fnOe[FLASH_PIN[k]][0]  = flashOe[k];
      fnOut[io_mux_pkg::PIN_SDIO_CMD + k][0] = sdioOut[k];
      fnOe[io_mux_pkg::PIN_SDIO_CMD + k][0]  = sdioOe[k];
      fnOut[io_mux_pkg::PIN_CS_FIRST + k][2] = fast_port_chip_selects[k];
      fnOe[io_mux_pkg::PIN_CS_FIRST + k][2]  = fastCsOe[k];
    end
    fnOut[io_mux_pkg::PIN_FAST_DATA_OUT][2] = fastOut[0];
    fnOe[io_mux_pkg::PIN_FAST_DATA_OUT][2]  = fastOe[0];
    for (int k = 1; k < 5; k++) begin
      // Pin 7 carries fast data in; pins 4..6 hold, wp, clock
      fnOut[(k == 1) ? 7 : k + 2][2] = fastOut[k];
      fnOe[(k == 1) ? 7 : k + 2][2]  = fastOe[k];
    end
  end

  // -------------------------------------------------------------
  // One slice per pin
  // -------------------------------------------------------------
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    pin_function_slice #(
      .TYPE0 (type0(p)),
      .TYPE2 (type2(p))
    ) u_slice (
      .clk      (clk),
      .rst      (rst),
      .selWrite (selWrite && (selPin == 5'(p))),
      .selData  (selData),
      .fnOut    (fnOut[p]),
      .fnOe     (fnOe[p]),
      .padIn    (padIn[p]),
      .selQ     (selState[2*p +: 2]),
      .fnIn     (fnIn[p]),
      .padOut   (padOut[p]),
      .padOe    (padOe[p])
    );
    assign matrixIn[p] = fnIn[p][1];
  end

  // Peripheral inputs from the slices, already defaulted when unselected
  assign test_mode_select_in = fnIn[io_mux_pkg::PIN_TEST_MODE][0];
  assign test_serial_in      = fnIn[io_mux_pkg::PIN_TEST_IN][0];
  assign test_clock_in       = fnIn[io_mux_pkg::PIN_TEST_CLOCK][0];
  assign serial0_receive     = fnIn[io_mux_pkg::PIN_SERIAL_RX][0];
  assign fastCs0In           = fnIn[io_mux_pkg::PIN_CS_FIRST][2];
  assign fastIn = {fnIn[6][2], fnIn[5][2], fnIn[4][2], fnIn[7][2],
                   fnIn[io_mux_pkg::PIN_FAST_DATA_OUT][2]};
  for (genvar k = 0; k < 6; k++) begin : g_grp
    assign flashIn[k] = fnIn[FLASH_PIN[k]][0];
    assign sdioIn[k]  = fnIn[io_mux_pkg::PIN_SDIO_CMD + k][0];
  end

endmodule // io_pin_function_mux

// ### rtl/io_mux_pkg.sv
// Purpose: Shared constants for the IO pin function multiplexer.
// Assumes: Pin numbering follows the 40-pin package IO table.
// Notes:   Pin index is the GPIO number, 0 to 30.
package io_mux_pkg;

  localparam int PIN_COUNT = 31;
  localparam int SEL_WIDTH = 2;

  // Function selector codes
  typedef enum logic [1:0] {
    FUNC_DIRECT  = 2'b00,
    FUNC_MATRIX  = 2'b01,
    FUNC_ALT     = 2'b10,
    FUNC_UNUSED  = 2'b11
  } func_sel_t;

  // Direction type of one pin function
  typedef enum logic [2:0] {
    TYPE_NONE      = 3'b000,
    TYPE_IN_HIGH   = 3'b001,
    TYPE_OUT       = 3'b010,
    TYPE_OUT_TRI   = 3'b011,
    TYPE_IN_OUT    = 3'b100,
    TYPE_IN_HIGH_OT = 3'b101
  } dir_type_t;

  localparam logic [1:0] SEL_RESET = 2'h0;

  // Fixed pin positions of the direct paths
  localparam int PIN_FAST_DATA_OUT = 2;
  localparam int PIN_TEST_MODE     = 4;
  localparam int PIN_TEST_IN       = 5;
  localparam int PIN_TEST_CLOCK    = 6;
  localparam int PIN_TEST_OUT      = 7;
  localparam int PIN_FLASH_CS      = 24;
  localparam int PIN_FLASH_DOUT    = 25;
  localparam int PIN_FLASH_WP      = 26;
  localparam int PIN_FLASH_HOLD    = 28;
  localparam int PIN_FLASH_CLK     = 29;
  localparam int PIN_FLASH_DIN     = 30;
  localparam int PIN_SERIAL_TX     = 16;
  localparam int PIN_SERIAL_RX     = 17;
  localparam int PIN_CS_FIRST      = 16;
  localparam int PIN_SDIO_CMD      = 18;
  localparam int PIN_SDIO_CLK      = 19;
  localparam int PIN_SDIO_DATA0    = 20;

  localparam int FAST_CS_COUNT = 6;
  localparam int SDIO_DATA_WIDTH = 4;

endpackage

// ### rtl/pin_function_slice.sv
// Purpose: One pin: selector register, output choice and input gating.
// Assumes: Function inputs are synchronous to clk.
// Notes:   Unselected function inputs see their default level.
`timescale 1ns/1ps
module pin_function_slice #(
  parameter io_mux_pkg::dir_type_t TYPE0 = io_mux_pkg::TYPE_IN_OUT,
  parameter io_mux_pkg::dir_type_t TYPE2 = io_mux_pkg::TYPE_NONE
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       selWrite,
  input  wire logic [1:0] selData,
  input  wire logic [2:0] fnOut,
  input  wire logic [2:0] fnOe,
  input  wire logic       padIn,
  output logic [1:0]      selQ,
  output logic [2:0]      fnIn,
  output logic            padOut,
  output logic            padOe
);

  logic [1:0] sel_reg;
  logic [1:0] sel_next;
  logic       padOut_reg;
  logic       padOe_reg;
  logic [2:0] fnIn_reg;
  logic       legal;
  wire        in0Cap  = (TYPE0 != io_mux_pkg::TYPE_OUT) && (TYPE0 != io_mux_pkg::TYPE_OUT_TRI);
  wire        out0Cap = (TYPE0 != io_mux_pkg::TYPE_IN_HIGH);
  wire        in2Cap  = (TYPE2 != io_mux_pkg::TYPE_OUT_TRI) && (TYPE2 != io_mux_pkg::TYPE_NONE);
  wire        out2Cap = (TYPE2 != io_mux_pkg::TYPE_NONE) && (TYPE2 != io_mux_pkg::TYPE_IN_HIGH);
  wire        dflt0   = (TYPE0 == io_mux_pkg::TYPE_IN_HIGH) ||
                        (TYPE0 == io_mux_pkg::TYPE_IN_HIGH_OT);
  wire        dflt2   = (TYPE2 == io_mux_pkg::TYPE_IN_HIGH_OT);

  // Illegal or missing functions are refused, selection kept
  assign legal    = (selData == 2'h0) || (selData == 2'h1) ||
                    ((selData == 2'h2) && (TYPE2 != io_mux_pkg::TYPE_NONE));
  assign sel_next = (selWrite && legal) ? selData : sel_reg;

  // -------------------------------------------------------------
  // Registered pin and function paths
  // -------------------------------------------------------------
  // Registering avoids glitches on unselected inputs while sel moves
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_reg    <= io_mux_pkg::SEL_RESET;
      padOut_reg <= 1'b0;
      padOe_reg  <= 1'b0;
      // Default-high inputs stay high through reset as well
      fnIn_reg   <= {dflt2, 1'b0, dflt0};
    end else begin
      sel_reg    <= sel_next;
      padOut_reg <= (sel_reg == 2'h0) ? fnOut[0] :
                    (sel_reg == 2'h1) ? fnOut[1] : fnOut[2];
      // Only O-capable functions may drive; T releases the pad
      padOe_reg  <= (sel_reg == 2'h0) ? (fnOe[0] & out0Cap) :
                    (sel_reg == 2'h1) ? fnOe[1] :
                    (fnOe[2] & out2Cap);
      fnIn_reg[0] <= (sel_reg == 2'h0 && in0Cap) ? padIn : dflt0;
      fnIn_reg[1] <= (sel_reg == 2'h1) ? padIn : 1'b0;
      fnIn_reg[2] <= (sel_reg == 2'h2 && in2Cap) ? padIn : dflt2;
    end
  end

  assign selQ   = sel_reg;
  assign fnIn   = fnIn_reg;
  assign padOut = padOut_reg;
  assign padOe  = padOe_reg;

endmodule // pin_function_slice

// ### verification/io_mux_sva.sv
// Purpose: Port checker for the pin function multiplexer.
// Assumes: Paths answer one edge after the selector register.
// Notes:   Watches pins 0, 3, 4, 16, 17 and 24 only, to stay small.
`timescale 1ns/1ps
module io_mux_sva #(
  parameter int PINS = 31
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              selWrite,
  input wire logic [4:0]        selPin,
  input wire logic [1:0]        selData,
  input wire logic [2*PINS-1:0] selState,
  input wire logic [PINS-1:0]   padIn,
  input wire logic [PINS-1:0]   padOut,
  input wire logic [PINS-1:0]   padOe,
  input wire logic [PINS-1:0]   matrixOut,
  input wire logic [PINS-1:0]   matrixOe,
  input wire logic [PINS-1:0]   matrixIn,
  input wire logic              test_mode_select_in,
  input wire logic [4:0]        fastIn,
  input wire logic [4:0]        fastOe,
  input wire logic              serial0_transmit,
  input wire logic              serial0_receive,
  input wire logic [5:0]        flashOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_take; selWrite && selPin == 5'h4 && selData != 2'h3 |=> selState[9:8] == $past(selData); endproperty
  a_take: assert property (p_take) else $error("selector write lost");
  property p_refuse; selWrite && selPin == 5'h3 && selData == 2'h2 |=> $stable(selState[7:6]); endproperty
  a_refuse: assert property (p_refuse) else $error("missing function taken");
  property p_tms_idle; selState[9:8] != 2'h0 |=> test_mode_select_in; endproperty
  a_tms_idle: assert property (p_tms_idle) else $error("mode input not high");
  property p_tms_pass; selState[9:8] == 2'h0 |=> test_mode_select_in == $past(padIn[4]); endproperty
  a_tms_pass: assert property (p_tms_pass) else $error("mode input wrong");
  property p_in_only; selState[9:8] == 2'h0 |=> !padOe[4]; endproperty
  a_in_only: assert property (p_in_only) else $error("input function drives");
  property p_hold; selState[9:8] == 2'h2 |=> padOe[4] == $past(fastOe[2]) && fastIn[2] == $past(padIn[4]); endproperty
  a_hold: assert property (p_hold) else $error("hold path wrong");
  property p_matrix; selState[1:0] == 2'h1 |=> padOut[0] == $past(matrixOut[0]) && padOe[0] == $past(matrixOe[0]); endproperty
  a_matrix: assert property (p_matrix) else $error("matrix path wrong");
  property p_matrix_idle; selState[1:0] != 2'h1 |=> !matrixIn[0]; endproperty
  a_matrix_idle: assert property (p_matrix_idle) else $error("matrix input not low");
  property p_tx; selState[33:32] == 2'h0 |=> padOe[16] && padOut[16] == $past(serial0_transmit); endproperty
  a_tx: assert property (p_tx) else $error("transmit path wrong");
  property p_rx_idle; selState[35:34] != 2'h0 |=> serial0_receive; endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("receive not high");
  property p_flash_cs; selState[49:48] == 2'h0 |=> padOe[24] == $past(flashOe[0]); endproperty
  a_flash_cs: assert property (p_flash_cs) else $error("flash select wrong");
endmodule // io_mux_sva

// ### verification/peripheral_model.sv
// Purpose: Peripheral and matrix side driving the multiplexer.
// Assumes: New values only when step is high, so checks see steady data.
// Notes:   Enables are random too, so released lines get exercised.
`timescale 1ns/1ps
module peripheral_model (
  input  wire logic        clk,
  input  wire logic        step,
  input  wire logic [31:0] rnd,
  output logic [30:0]      matrixOut,
  output logic [30:0]      matrixOe,
  output logic             test_serial_out,
  output logic             testOutOe,
  output logic             serial0_transmit,
  output logic [5:0]       flashOut,
  output logic [5:0]       flashOe,
  output logic [4:0]       fastOut,
  output logic [4:0]       fastOe,
  output logic [5:0]       fast_port_chip_selects,
  output logic [5:0]       fastCsOe,
  output logic [5:0]       sdioOut,
  output logic [5:0]       sdioOe
);
  always_ff @(posedge clk) begin
    if (step) begin
      matrixOut <= rnd[30:0];
      matrixOe <= rnd[31:1];
      {test_serial_out, testOutOe, serial0_transmit} <= rnd[2:0];
      {flashOut, flashOe} <= rnd[23:12];
      {fastOut, fastOe} <= rnd[29:20];
      {fast_port_chip_selects, fastCsOe} <= rnd[11:0];
      {sdioOut, sdioOe} <= rnd[31:20];
    end
  end
endmodule // peripheral_model

// ### verification/testbench.sv
// Purpose: Self-checking bench for the pin function multiplexer.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   A shadow copy of the selectors follows every legal write.
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        selWrite = 1'b0;
  logic        step = 1'b1;
  logic [4:0]  selPin = 5'h0;
  logic [1:0]  selData = 2'h0;
  logic [1:0]  s;
  logic [30:0] padIn = 31'h0;
  logic [31:0] rnd = 32'h0000_004A;
  logic [61:0] selState;
  logic [61:0] shadow = 62'h0;
  logic [30:0] padOut, padOe, matrixIn, matrixOut, matrixOe;
  logic [5:0]  flashOut, flashOe, flashIn, fast_port_chip_selects, fastCsOe, sdioOut, sdioOe;
  logic [5:0]  sdioIn;
  logic [4:0]  fastOut, fastOe, fastIn;
  logic        test_mode_select_in, test_serial_in, test_clock_in, test_serial_out, testOutOe;
  logic        serial0_transmit, serial0_receive, fastCs0In;
  int          fails = 0;
  int          cmp_count = 0;
  always #4 clk = ~clk;
  io_pin_function_mux dut (.clk, .rst, .selWrite, .selPin, .selData, .selState, .padIn,
    .padOut, .padOe, .matrixOut, .matrixOe, .matrixIn, .test_mode_select_in, .test_serial_in,
    .test_clock_in, .test_serial_out, .testOutOe, .serial0_transmit, .serial0_receive,
    .flashOut, .flashOe, .flashIn, .fastOut, .fastOe, .fastIn, .fast_port_chip_selects,
    .fastCsOe, .fastCs0In, .sdioOut, .sdioOe, .sdioIn);
  peripheral_model pm (.clk, .step, .rnd, .matrixOut, .matrixOe, .test_serial_out, .testOutOe,
    .serial0_transmit, .flashOut, .flashOe, .fastOut, .fastOe, .fast_port_chip_selects,
    .fastCsOe, .sdioOut, .sdioOe);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic legal(input logic [4:0] p, input logic [1:0] d);
    return d < 2'h2 || (d == 2'h2 && (p == 5'h2 || (p >= 5'h4 && p <= 5'h7)
      || (p >= 5'h10 && p <= 5'h15)));
  endfunction
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [61:0] got, input logic [61:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [4:0] p, input logic [1:0] d);
    selWrite = 1'b1;
    selPin = p;
    selData = d;
    tick();
    if (legal(p, d)) shadow[2*p +: 2] = d;
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    padIn = 31'h1555_5555;
    tick();
    tick();
    chk(selState, 62'h0, "reset selectors");
    chk(padOe[16], 1'b1, "transmit not driven");
    chk(padOe[19], 1'b0, "card clock driven");
    chk(sdioIn[1], padIn[19], "card clock input");
    chk(test_serial_in, padIn[5], "test data input");
    chk(test_clock_in, padIn[6], "test clock input");
    chk(flashIn[1], padIn[25], "flash data out input");
    chk(flashIn[5], padIn[30], "flash data in input");
    chk(fastCs0In, 1'b1, "select 0 input not high");
    step = 1'b0;
    // Codes 2, 3, 0, 1 on two pins back to back; code 3 and pin 3 code 2 refused
    for (int c = 0; c < 4; c++) begin
      rnd = xs(rnd);
      padIn = rnd[30:0];
      wr(5'h4, 2'(c + 2));
      wr(5'h11, 2'(c + 2));
      wr(5'h3, 2'h2);
      selWrite = 1'b0;
      tick();
      chk(selState, shadow, "selectors");
      s = shadow[9:8];
      chk(test_mode_select_in, s == 2'h0 ? padIn[4] : 1'b1, "mode input");
      chk(fastIn[2], s == 2'h2 ? padIn[4] : 1'b1, "hold input");
      chk(padOe[4], s == 2'h0 ? 1'b0 : (s == 2'h1 ? matrixOe[4] : fastOe[2]), "pin 4 oe");
      s = shadow[35:34];
      chk(serial0_receive, s == 2'h0 ? padIn[17] : 1'b1, "receive input");
      chk(padOe[17], s == 2'h0 ? 1'b0 : (s == 2'h1 ? matrixOe[17] : fastCsOe[1]), "pin 17 oe");
    end
    step = 1'b1;
    repeat (300) begin
      rnd = xs(rnd);
      selWrite = rnd[0];
      selPin = 5'(rnd[12:8] % 31);
      selData = rnd[17:16];
      padIn = rnd[31:1];
      tick();
      if (selWrite && legal(selPin, selData)) shadow[2*selPin +: 2] = selData;
      chk(selState, shadow, "random selectors");
    end
    selWrite = 1'b0;
    rst = 1'b1;
    tick();
    tick();
    rst = 1'b0;
    shadow = 62'h0;
    tick();
    chk(selState, shadow, "selectors after reset");
    chk(padOe[16], 1'b1, "transmit not driven after reset");
    complete_run();
  end
  initial begin
    #20000;
    fails++;
    complete_run();
  end
endmodule // testbench
bind io_pin_function_mux io_mux_sva #(.PINS(PINS)) chk_i (.clk, .rst, .selWrite, .selPin,
  .selData, .selState, .padIn, .padOut, .padOe, .matrixOut, .matrixOe, .matrixIn,
  .test_mode_select_in, .fastIn, .fastOe, .serial0_transmit, .serial0_receive, .flashOe);
